// ---- core/dsp_mac_block.sv ----
// dsp_mac_block.sv: configurable multiply / accumulate / adder block
// assumes core_clk is the row clock that feeds it and all inputs are
// synchronous to it; results show three edges after the operands.
// Function
// RQ1 - eight 9x9, four 18x18 or one 36x36 multiplier, each product out
// RQ2 - two 52-bit multiply-accumulate units at 9x9 or 18x18, not 36x36
// RQ3 - two-product adder: four sums at 9x9, two sums at 18x18
// RQ4 - four-product adder: two sums at 9x9, one sum at 18x18
// RQ5 - at 36x36 only the product; add or accumulate lives outside
// RQ6 - full 36x36 when both operands share fixed signedness
// RQ7 - mixed fixed signs: unsigned operand limited to 35 bits
// RQ8 - dynamic signs: 36x36 with one control, 35x35 with two
// RQ9 - one dynamic, one fixed: the dynamic operand limited to 35 bits
// RQ10 - filter mode: four-product adder fed by data and coefficient chains
// RQ11 - one block is an 18-bit FIR of up to four taps; longer cascades
// RQ12 - shift chains pass down the column to the next block
// RQ13 - registers clock only from the row-local clock
// RQ14 - each input shift stage is 18 bits wide
// RQ15 - signed values two's complement, unsigned plain binary
module dsp_mac_block (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dsp_pkg::mode_t mode,
  input wire dsp_pkg::size_t size,
  input wire logic [71:0] a_in,
  input wire logic [71:0] b_in,
  input wire logic a_sgn,
  input wire logic b_sgn,
  input wire logic a_dyn,
  input wire logic b_dyn,
  input wire logic sign_shared,
  input wire logic [3:0] add_sub,
  input wire logic [1:0] acc_load,
  input wire logic [1:0] acc_sub,
  input wire logic fir_en,
  input wire logic data_shift,
  input wire logic coef_shift,
  input wire logic coef_load,
  input wire logic [71:0] coef_par,
  input wire logic [17:0] chain_data_in,
  input wire logic [17:0] chain_coef_in,
  output logic [17:0] chain_data_out,
  output logic [17:0] chain_coef_out,
  output logic [143:0] result,
  output logic cfg_err,
  output logic op_err
);
  import dsp_pkg::*;

  // operand sign and width shaping, all in front of stage 1
  wire shared = sign_shared & a_dyn & b_dyn; // RQ8
  wire sa = a_sgn;
  wire sb = shared ? a_sgn : b_sgn;
  wire fixed_mix = ~a_dyn & ~b_dyn & (sa ^ sb);
  wire lim_a = (a_dyn & ~shared) | (fixed_mix & ~sa); // RQ7 RQ8 RQ9
  wire lim_b = (b_dyn & ~shared) | (fixed_mix & ~sb); // RQ7 RQ8 RQ9
  wire in36 = (size == SZ_36);
  // a 35-bit operand sees bit 35 as a copy of bit 34 when signed, as zero when unsigned
  wire a_top = lim_a ? (sa & a_in[34]) : a_in[35];
  wire b_top = lim_b ? (sb & b_in[34]) : b_in[35];
  wire [OP_W-1:0] a_eff = in36 ?
    {a_in[71:36], a_top, a_in[34:0]} : a_in; // RQ6
  wire [OP_W-1:0] b_eff = in36 ?
    {b_in[71:36], b_top, b_in[34:0]} : b_in; // RQ6
  wire op_err_nxt = in36 &
    ((a_top != a_in[35]) | (b_top != b_in[35]));
  wire fir_ok = (size == SZ_18) & (mode == MD_ADD4);
  wire cfg_err_nxt = (in36 & (mode != MD_MUL)) |
    (size == 2'b11) | (fir_en & ~fir_ok); // RQ5 RQ10

  // stage 1: operand and control registers
  logic [OP_W-1:0] a_r;
  logic [OP_W-1:0] b_r;
  logic sa_r;
  logic sb_r;
  logic fir_r;
  size_t size_r;
  mode_t mode_r;
  logic [3:0] add_sub_r;
  logic [1:0] acc_load_r;
  logic [1:0] acc_sub_r;
  logic cfg_err_r;
  logic op_err_r;

  always_ff @(posedge core_clk or negedge arst_n) // RQ13
  begin
    if (!arst_n)
    begin
      a_r <= '0;
      b_r <= '0;
      sa_r <= 1'b0;
      sb_r <= 1'b0;
      fir_r <= 1'b0;
      size_r <= SZ_9;
      mode_r <= MD_MUL;
      add_sub_r <= 4'h0;
      acc_load_r <= 2'h0;
      acc_sub_r <= 2'h0;
      cfg_err_r <= 1'b0;
      op_err_r <= 1'b0;
    end
    else
    begin
      a_r <= a_eff;
      b_r <= b_eff;
      sa_r <= sa;
      sb_r <= sb;
      fir_r <= fir_en;
      size_r <= size;
      mode_r <= mode;
      add_sub_r <= add_sub;
      acc_load_r <= acc_load;
      acc_sub_r <= acc_sub;
      cfg_err_r <= cfg_err_nxt;
      op_err_r <= op_err_nxt;
    end
  end

  // input shift chains: samples and coefficients
  tap_if #(.W(HALF_W), .N(TAP_N)) data_tp ();
  tap_if #(.W(HALF_W), .N(TAP_N)) coef_tp ();

  assign data_tp.ser_in = chain_data_in;
  assign data_tp.shift = data_shift;
  assign data_tp.par_load = 1'b0;
  assign data_tp.par_data = '0;
  assign coef_tp.ser_in = chain_coef_in;
  assign coef_tp.shift = coef_shift; // RQ10
  assign coef_tp.par_load = coef_load; // RQ10
  assign coef_tp.par_data = coef_par;

  tap_chain #(.W(HALF_W), .N(TAP_N)) u_data_chain (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tp(data_tp)
  );

  tap_chain #(.W(HALF_W), .N(TAP_N)) u_coef_chain (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tp(coef_tp)
  );

  assign chain_data_out = data_tp.ser_out; // RQ12
  assign chain_coef_out = coef_tp.ser_out; // RQ12

  // stage 2: four lanes; at 36x36 they form the four partial products
  wire is36_r = (size_r == SZ_36);
  wire split_r = (size_r == SZ_9) & ~fir_r;
  lane_if #(.W(HALF_W)) lf [LANE_N] ();
  wire signed [WIDE_W-1:0] p18 [LANE_N];
  wire signed [WIDE_W-1:0] p9 [2*LANE_N];
  wire [RES_W-1:0] prods;

  genvar k;
  generate
    for (k = 0; k < LANE_N; k++)
    begin : g_lane
      localparam int XH = k % 2;
      localparam int YH = k / 2;
      wire [HALF_W-1:0] xa = is36_r ?
        a_r[XH*HALF_W +: HALF_W] : a_r[k*HALF_W +: HALF_W];
      wire [HALF_W-1:0] yb = is36_r ?
        b_r[YH*HALF_W +: HALF_W] : b_r[k*HALF_W +: HALF_W];
      // the filter feeds tap k of both chains into lane k
      assign lf[k].x = fir_r ?
        data_tp.taps[k*HALF_W +: HALF_W] : xa; // RQ10 RQ11
      assign lf[k].y = fir_r ?
        coef_tp.taps[k*HALF_W +: HALF_W] : yb; // RQ10 RQ11
      // low halves of a split 36-bit operand are always magnitudes
      assign lf[k].x_sgn = is36_r ? (sa_r & (XH == 1)) : sa_r;
      assign lf[k].y_sgn = is36_r ? (sb_r & (YH == 1)) : sb_r;
      assign lf[k].split = split_r;

      mult_lane #(.W(HALF_W)) u_lane (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .lp(lf[k])
      );

      wire [PROD_W-1:0] pr = lf[k].prod;
      wire ps = lf[k].prod_sgn;
      assign p18[k] = {{(WIDE_W-PROD_W){ps & pr[PROD_W-1]}}, pr}; // RQ15
      assign p9[2*k] = {{(WIDE_W-HALF_W){ps & pr[HALF_W-1]}},
        pr[HALF_W-1:0]}; // RQ15
      assign p9[2*k+1] = {{(WIDE_W-HALF_W){ps & pr[PROD_W-1]}},
        pr[PROD_W-1:HALF_W]}; // RQ15
      assign prods[k*PROD_W +: PROD_W] = pr; // RQ1
    end
  endgenerate

  // stage 2 control is registered on the same edge as the lane products
  size_t size_q;
  mode_t mode_q;
  logic [3:0] add_sub_q;
  logic [1:0] acc_load_q;
  logic [1:0] acc_sub_q;
  logic cfg_err_q;
  logic op_err_q;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      size_q <= SZ_9;
      mode_q <= MD_MUL;
      add_sub_q <= 4'h0;
      acc_load_q <= 2'h0;
      acc_sub_q <= 2'h0;
      cfg_err_q <= 1'b0;
      op_err_q <= 1'b0;
    end
    else
    begin
      size_q <= fir_r ? SZ_18 : size_r;
      mode_q <= fir_r ? MD_ADD4 : mode_r;
      add_sub_q <= fir_r ? 4'h0 : add_sub_r;
      acc_load_q <= acc_load_r;
      acc_sub_q <= acc_sub_r;
      cfg_err_q <= cfg_err_r;
      op_err_q <= op_err_r;
    end
  end

  // adder trees
  wire signed [WIDE_W-1:0] s9_2 [4];
  wire signed [WIDE_W-1:0] s18_2 [2];
  wire signed [WIDE_W-1:0] s9_4 [2];
  wire [RES_W-1:0] r_add2_9;
  wire [RES_W-1:0] r_add2_18;
  wire [RES_W-1:0] r_add4_9;

  genvar j;
  generate
    for (j = 0; j < 4; j++)
    begin : g_pair9
      assign s9_2[j] = add_sub_q[j] ?
        p9[2*j] - p9[2*j+1] : p9[2*j] + p9[2*j+1]; // RQ3
      assign r_add2_9[j*PROD_W +: PROD_W] = s9_2[j][PROD_W-1:0];
    end
    for (j = 0; j < 2; j++)
    begin : g_pair18
      assign s18_2[j] = add_sub_q[j] ?
        p18[2*j] - p18[2*j+1] : p18[2*j] + p18[2*j+1]; // RQ3
      assign r_add2_18[j*OP_W +: OP_W] = s18_2[j][OP_W-1:0];
      assign s9_4[j] = s9_2[2*j] + s9_2[2*j+1]; // RQ4
      assign r_add4_9[j*OP_W +: OP_W] = s9_4[j][OP_W-1:0];
    end
  endgenerate

  wire signed [WIDE_W-1:0] s18_4 = s18_2[0] + s18_2[1]; // RQ4 RQ11
  wire [RES_W-1:0] r_add4_18 = {72'h0, s18_4[OP_W-1:0]};

  // 36x36 recombined from the four 18x18 partial products
  wire signed [WIDE_W-1:0] mid = p18[1] + p18[2];
  wire signed [WIDE_W-1:0] p36 = (p18[3] <<< FULL_SHIFT) +
    (mid <<< MID_SHIFT) + p18[0]; // RQ1 RQ6
  wire [RES_W-1:0] r_mul36 = {72'h0, p36[OP_W-1:0]}; // RQ5

  // two accumulators; unit u takes the first product of lane 2u
  logic [ACC_W-1:0] acc_r [MAC_N];
  wire [ACC_W-1:0] acc_nxt [MAC_N];
  wire [RES_W-1:0] r_mac;

  genvar u;
  generate
    for (u = 0; u < MAC_N; u++)
    begin : g_mac
      wire signed [WIDE_W-1:0] m = (size_q == SZ_9) ? p9[4*u] : p18[2*u];
      wire [ACC_W-1:0] mt = m[ACC_W-1:0];
      wire [ACC_W-1:0] base = acc_load_q[u] ? ACC_RST : acc_r[u];
      assign acc_nxt[u] = acc_sub_q[u] ? base - mt : base + mt; // RQ2
      // the accumulator only moves in accumulate mode below 36x36
      wire acc_go = (mode_q == MD_MAC) & (size_q != SZ_36);
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          acc_r[u] <= ACC_RST;
        else if (acc_go)
          acc_r[u] <= acc_nxt[u]; // RQ2
      end
      assign r_mac[u*ACC_W +: ACC_W] = acc_nxt[u];
    end
  endgenerate

  assign r_mac[RES_W-1:MAC_N*ACC_W] = '0;

  // stage 3: result selection; 36x36 gives the bare product unless the filter is on
  wire q36 = (size_q == SZ_36);
  wire q9 = (size_q == SZ_9);
  wire [RES_W-1:0] r_add2 = q9 ? r_add2_9 : r_add2_18;
  wire [RES_W-1:0] r_add4 = q9 ? r_add4_9 : r_add4_18;
  wire [RES_W-1:0] res_nxt = q36 ? r_mul36 : // RQ5
    (mode_q == MD_MAC) ? r_mac :
    (mode_q == MD_ADD2) ? r_add2 :
    (mode_q == MD_ADD4) ? r_add4 : prods;
  logic [RES_W-1:0] result_r;
  logic cfg_err_o_r;
  logic op_err_o_r;

  always_ff @(posedge core_clk or negedge arst_n) // RQ13
  begin
    if (!arst_n)
    begin
      result_r <= RES_RST;
      cfg_err_o_r <= 1'b0;
      op_err_o_r <= 1'b0;
    end
    else
    begin
      result_r <= res_nxt;
      cfg_err_o_r <= cfg_err_q;
      op_err_o_r <= op_err_q;
    end
  end

  assign result = result_r;
  assign cfg_err = cfg_err_o_r;
  assign op_err = op_err_o_r;
endmodule

// ---- pkg/dsp_pkg.sv ----
// dsp_pkg.sv: shared types and constants of the arithmetic block
// assumes every design file imports it whole
package dsp_pkg;

  typedef enum logic [1:0]
  {
    SZ_9 = 2'b00,
    SZ_18 = 2'b01,
    SZ_36 = 2'b10
  } size_t;

  typedef enum logic [1:0]
  {
    MD_MUL = 2'b00,
    MD_MAC = 2'b01,
    MD_ADD2 = 2'b10,
    MD_ADD4 = 2'b11
  } mode_t;

  localparam int SUB_W = 9;
  localparam int HALF_W = 18;
  localparam int PROD_W = 36;
  localparam int OP_W = 72;
  localparam int RES_W = 144;
  localparam int ACC_W = 52;
  localparam int WIDE_W = 80;
  localparam int LANE_N = 4;
  localparam int MAC_N = 2;
  localparam int TAP_N = 4;
  localparam int FULL_SHIFT = 36;
  localparam int MID_SHIFT = 18;
  localparam int PIPE_STAGES = 3;
  localparam logic [RES_W-1:0] RES_RST = 144'h0;
  localparam logic [ACC_W-1:0] ACC_RST = 52'h0;
  localparam logic [HALF_W-1:0] TAP_RST = 18'h0;
  localparam logic [PROD_W-1:0] PROD_RST = 36'h0;

endpackage

// ---- pkg/lane_if.sv ----
// lane_if.sv: operands in and product out of one 18x18 multiplier lane
// assumes the lane registers its product once per clock
interface lane_if #(parameter int W = 18);
  logic [W-1:0] x;
  logic [W-1:0] y;
  logic x_sgn;
  logic y_sgn;
  logic split;
  logic [2*W-1:0] prod;
  logic prod_sgn;
  modport drv (output x, y, x_sgn, y_sgn, split, input prod, prod_sgn);
  modport lane (input x, y, x_sgn, y_sgn, split, output prod, prod_sgn);
endinterface

// ---- pkg/tap_if.sv ----
// tap_if.sv: one input shift chain, serial and parallel sides
// assumes tap 0 holds the newest word
interface tap_if #(parameter int W = 18, parameter int N = 4);
  logic [W-1:0] ser_in;
  logic shift;
  logic par_load;
  logic [N*W-1:0] par_data;
  logic [N*W-1:0] taps;
  logic [W-1:0] ser_out;
  modport ctl (output ser_in, shift, par_load, par_data,
    input taps, ser_out);
  modport chain (input ser_in, shift, par_load, par_data,
    output taps, ser_out);
endinterface

// ---- core/mult_lane.sv ----
// mult_lane.sv: one 18x18 multiplier that can split into two 9x9
// assumes operand signs are given per operand by the driving block
module mult_lane #(
  parameter int W = 18
) (
  input wire logic core_clk,
  input wire logic arst_n,
  lane_if.lane lp
);
  import dsp_pkg::*;

  localparam int H = W / 2;

  // one extra bit carries the sign, so unsigned stays a plain magnitude
  wire signed [W:0] x_full = {lp.x_sgn & lp.x[W-1], lp.x}; // RQ15
  wire signed [W:0] y_full = {lp.y_sgn & lp.y[W-1], lp.y}; // RQ15
  wire signed [H:0] x_lo = {lp.x_sgn & lp.x[H-1], lp.x[H-1:0]};
  wire signed [H:0] y_lo = {lp.y_sgn & lp.y[H-1], lp.y[H-1:0]};
  wire signed [H:0] x_hi = {lp.x_sgn & lp.x[W-1], lp.x[W-1:H]};
  wire signed [H:0] y_hi = {lp.y_sgn & lp.y[W-1], lp.y[W-1:H]};
  wire signed [2*W+1:0] p_full = x_full * y_full;
  wire signed [2*H+1:0] p_lo = x_lo * y_lo;
  wire signed [2*H+1:0] p_hi = x_hi * y_hi;
  wire [2*W-1:0] prod_nxt = lp.split ?
    {p_hi[2*H-1:0], p_lo[2*H-1:0]} : p_full[2*W-1:0]; // RQ1
  logic [2*W-1:0] prod_r;
  logic sgn_r;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prod_r <= PROD_RST;
      sgn_r <= 1'b0;
    end
    else
    begin
      prod_r <= prod_nxt;
      sgn_r <= lp.x_sgn | lp.y_sgn;
    end
  end

  assign lp.prod = prod_r;
  assign lp.prod_sgn = sgn_r;
endmodule

// ---- core/tap_chain.sv ----
// tap_chain.sv: input shift chain of 18-bit taps, serial or parallel
// assumes shift and parallel load are never wanted in one cycle;
// parallel load wins if they are
module tap_chain #(
  parameter int W = 18,
  parameter int N = 4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  tap_if.chain tp
);
  import dsp_pkg::*;

  logic [W-1:0] tap_r [N];

  genvar k;
  generate
    for (k = 0; k < N; k++)
    begin : g_tap
      wire [W-1:0] from_prev;
      if (k == 0)
      begin : g_head
        assign from_prev = tp.ser_in;
      end
      else
      begin : g_body
        assign from_prev = tap_r[k-1];
      end
      wire [W-1:0] tap_nxt = tp.par_load ? tp.par_data[k*W +: W] :
        tp.shift ? from_prev : tap_r[k];
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          tap_r[k] <= TAP_RST;
        else
          tap_r[k] <= tap_nxt; // RQ14
      end
      assign tp.taps[k*W +: W] = tap_r[k];
    end
  endgenerate

  // the last tap leaves the block for the next one down the column
  assign tp.ser_out = tap_r[N-1]; // RQ12
endmodule

// ---- tb/fabric_model.sv ----
// fabric_model.sv: block above in the column, feeding both shift chains
// assumes the same row clock as the block under test
module fabric_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hold,
  input wire logic [17:0] hold_val,
  output logic [17:0] data_word,
  output logic [17:0] coef_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // the data word changes every cycle unless hold is set, the coefficient word every cycle, so a missed or doubled shift shows up
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_word <= 18'h0;
      coef_word <= 18'h0;
    end
    else
    begin
      data_word <= hold ? hold_val : ~data_word + 18'h5;
      coef_word <= coef_word + 18'h9;
    end
  end
endmodule

// ---- tb/dsp_mac_block_asserts.sv ----
// dsp_mac_block_asserts.sv: port-level checks of the arithmetic block
// assumes results appear three edges after the operands are sampled
module dsp_mac_block_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dsp_pkg::mode_t mode,
  input wire dsp_pkg::size_t size,
  input wire logic [71:0] a_in,
  input wire logic [71:0] b_in,
  input wire logic a_sgn,
  input wire logic b_sgn,
  input wire logic a_dyn,
  input wire logic b_dyn,
  input wire logic sign_shared,
  input wire logic [3:0] add_sub,
  input wire logic [1:0] acc_load,
  input wire logic [1:0] acc_sub,
  input wire logic fir_en,
  input wire logic data_shift,
  input wire logic coef_shift,
  input wire logic coef_load,
  input wire logic [71:0] coef_par,
  input wire logic [17:0] chain_data_in,
  input wire logic [17:0] chain_coef_in,
  input wire logic [17:0] chain_data_out,
  input wire logic [17:0] chain_coef_out,
  input wire logic [143:0] result,
  input wire logic cfg_err,
  input wire logic op_err
);
  timeunit 1ns;
  timeprecision 1ps;
  import dsp_pkg::*;
  logic [3:0] run_n;
  logic [17:0] last_in;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // counts edges of steady shifting of one word; chain depth is unknown
  // here, so the check waits longer than any sane depth
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_n <= 4'h0;
      last_in <= 18'h0;
    end
    else
    begin
      last_in <= chain_data_in;
      if (data_shift && chain_data_in == last_in)
        run_n <= (run_n == 4'hf) ? run_n : run_n + 4'h1;
      else
        run_n <= 4'h0;
    end
  end
  chk_bad_size: assert property (size == 2'b11 |-> ##3 cfg_err)
    else $error("bad size not flagged");
  chk_wide_mode: assert property
    (size == SZ_36 && mode != MD_MUL |-> ##3 cfg_err)
    else $error("wide size with adder not flagged");
  chk_wide_upper: assert property
    (size == SZ_36 |-> ##3 result[143:72] == 72'h0)
    else $error("wide product upper half not zero");
  chk_mac_upper: assert property
    (mode == MD_MAC && size == SZ_18 && !fir_en |-> ##3
    result[143:104] == 40'h0)
    else $error("accumulator upper bits not zero");
  chk_sum4_upper: assert property
    (mode == MD_ADD4 && size == SZ_18 |-> ##3 result[143:72] == 72'h0)
    else $error("single four-product sum upper half not zero");
  chk_fir_size: assert property
    (fir_en && size == SZ_9 |-> ##3 cfg_err)
    else $error("filter at small size not flagged");
  chk_fir_ok: assert property
    ($past(fir_en, 3) && $past(size, 3) == SZ_18 &&
    $past(mode, 3) == MD_ADD4 |-> !cfg_err)
    else $error("legal filter setup flagged");
  chk_same_sign: assert property
    (size == SZ_36 && !a_dyn && !b_dyn && a_sgn == b_sgn |-> ##3 !op_err)
    else $error("matched sign wide product flagged");
  chk_chain_pass: assert property
    (run_n >= 4'h8 |-> chain_data_out == chain_data_in)
    else $error("data chain tail differs from steady input");
  cov_mac: cover property (mode == MD_MAC && size == SZ_9 ##1 mode == MD_MAC);
  cov_add2: cover property (mode == MD_ADD2 && add_sub != 4'h0);
  cov_fir: cover property (fir_en && data_shift [*4]);
endmodule

bind dsp_mac_block dsp_mac_block_asserts i_chk (
  .core_clk, .arst_n, .mode, .size, .a_in, .b_in, .a_sgn, .b_sgn,
  .a_dyn, .b_dyn, .sign_shared, .add_sub, .acc_load, .acc_sub, .fir_en,
  .data_shift, .coef_shift, .coef_load, .coef_par, .chain_data_in,
  .chain_coef_in, .chain_data_out, .chain_coef_out, .result, .cfg_err,
  .op_err
);

// ---- tb/tb_top.sv ----
// tb_top.sv: self-checking bench of the arithmetic block
// assumes dsp_pkg, the fabric model and the checker are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsp_pkg::*;
  typedef struct {bit dc; logic [143:0] r; logic ce; logic oe;} exp_t;
  localparam int LAT = 3;
  localparam int LIMIT = 2000;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  mode_t mode;
  size_t size;
  logic [71:0] a_in, b_in, coef_par;
  logic a_sgn, b_sgn, a_dyn, b_dyn, sign_shared, fir_en;
  logic data_shift, coef_shift, coef_load, hold, cfg_err, op_err;
  logic [3:0] add_sub;
  logic [1:0] acc_load, acc_sub;
  logic [17:0] chain_data_in, chain_coef_in, chain_data_out;
  logic [17:0] chain_coef_out, hold_val;
  logic [143:0] result;
  logic [51:0] acc_m [2] = '{52'h0, 52'h0};
  int seed = 10;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  exp_t q[$];

  dsp_mac_block i_dut (.core_clk, .arst_n, .mode, .size, .a_in, .b_in,
    .a_sgn, .b_sgn, .a_dyn, .b_dyn, .sign_shared, .add_sub, .acc_load,
    .acc_sub, .fir_en, .data_shift, .coef_shift, .coef_load, .coef_par,
    .chain_data_in, .chain_coef_in, .chain_data_out, .chain_coef_out,
    .result, .cfg_err, .op_err);
  fabric_model i_fab (.core_clk, .arst_n, .hold, .hold_val,
    .data_word(chain_data_in), .coef_word(chain_coef_in));

  initial
  begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp_w(string nm, logic [143:0] e, logic [143:0] s);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmp_b(string nm, logic e, logic s);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask

  function automatic logic signed [143:0] sx(logic [71:0] v, int w,
    logic s);
    logic signed [143:0] r;
    r = $signed(144'(v) & ((144'h1 << w) - 144'h1));
    if (s && v[w-1])
      r = r - $signed(144'h1 << w);
    return r;
  endfunction

  function automatic logic [143:0] put(logic [143:0] r, logic [143:0] v,
    int w, int pos);
    return r | ((v & ((144'h1 << w) - 144'h1)) << pos);
  endfunction

  function automatic logic signed [143:0] pr(int w, int j);
    return sx(a_in >> (w * j), w, a_sgn) * sx(b_in >> (w * j), w, b_sgn);
  endfunction

  // reference of one sampled input set; keeps its own accumulators
  task automatic predict(output exp_t e);
    int sz, w, n;
    logic signed [143:0] p, t;
    logic [71:0] a, b;
    logic bs, la, lb, ra, rb;
    e.dc = fir_en;
    e.r = '0;
    sz = (size == 2'b11) ? 1 : int'(size);
    w = 9 << sz;
    n = 8 >> sz;
    e.ce = size == 2'b11 || (sz == 2 && mode != MD_MUL) ||
      (fir_en && !(size == SZ_18 && mode == MD_ADD4));
    e.oe = 1'b0;
    if (sz == 2)
    begin
      bs = (a_dyn && b_dyn && sign_shared) ? a_sgn : b_sgn;
      la = (a_dyn && !sign_shared) ||
        (!a_dyn && !b_dyn && !a_sgn && bs);
      lb = (b_dyn && !sign_shared) ||
        (!a_dyn && !b_dyn && a_sgn && !bs);
      ra = a_sgn & a_in[34];
      rb = bs & b_in[34];
      e.oe = (la && a_in[35] != ra) || (lb && b_in[35] != rb);
      a = a_in;
      b = b_in;
      if (la)
        a[35] = ra;
      if (lb)
        b[35] = rb;
      p = sx(a, 36, a_sgn) * sx(b, 36, bs);
      e.r = put(e.r, p, 72, 0);
    end
    else if (mode == MD_MUL)
      for (int j = 0; j < n; j++)
        e.r = put(e.r, pr(w, j), 2 * w, 2 * w * j);
    else if (mode == MD_MAC)
      for (int u = 0; u < 2; u++)
      begin
        t = pr(w, n / 2 * u);
        acc_m[u] = (acc_load[u] ? 52'h0 : acc_m[u]) +
          (acc_sub[u] ? -t[51:0] : t[51:0]);
        e.r = put(e.r, 144'(acc_m[u]), 52, 52 * u);
      end
    else
      for (int j = 0; j < n / 2; j++)
      begin
        t = add_sub[j] ? pr(w, 2 * j) - pr(w, 2 * j + 1) :
          pr(w, 2 * j) + pr(w, 2 * j + 1);
        if (mode == MD_ADD2)
          e.r = put(e.r, t, 4 * w, 4 * w * j);
        else if (j % 2 == 1)
          e.r = put(e.r, p + t, 72, 72 * (j / 2));
        else
          p = t;
      end
  endtask

  always @(negedge core_clk)
  begin
    exp_t e, f;
    if (arst_n)
    begin
      predict(e);
      q.push_back(e);
      if (q.size() > LAT)
      begin
        f = q.pop_front();
        if (!f.dc)
          cmp_w("result", f.r, result);
        if (!f.dc)
          cmp_b("op_err", f.oe, op_err);
        cmp_b("cfg_err", f.ce, cfg_err);
      end
    end
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  initial
  begin
    logic signed [143:0] s;
    logic d1, d2, sh, sa;
    mode = MD_MUL;
    size = SZ_9;
    {a_in, b_in, coef_par} = '0;
    {a_sgn, b_sgn, a_dyn, b_dyn, sign_shared, fir_en} = '0;
    {data_shift, coef_shift, coef_load, hold, hold_val} = '0;
    {add_sub, acc_load, acc_sub} = '0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (600)
    begin
      d1 = 1'($random(seed));
      d2 = 1'($random(seed));
      sh = d1 & d2 & 1'($random(seed));
      sa = 1'($random(seed));
      mode <= mode_t'(2'($random(seed)));
      size <= size_t'(2'($random(seed)));
      a_in <= 72'({$random(seed), $random(seed), $random(seed)});
      b_in <= 72'({$random(seed), $random(seed), $random(seed)});
      a_sgn <= sa;
      // a shared control means both operands carry one sign
      b_sgn <= sh ? sa : 1'($random(seed));
      a_dyn <= d1;
      b_dyn <= d2;
      sign_shared <= sh;
      // differences wrap in two's complement for unsigned operands too
      add_sub <= 4'($random(seed));
      acc_load <= 2'($random(seed));
      acc_sub <= 2'($random(seed));
      data_shift <= 1'($random(seed));
      coef_shift <= 1'($random(seed));
      @(posedge core_clk);
    end
    mode <= MD_ADD4;
    size <= SZ_18;
    {a_sgn, b_sgn, a_dyn, b_dyn, sign_shared} <= 5'b11000;
    {add_sub, data_shift, coef_shift, hold} <= 7'h01;
    hold_val <= 18'($random(seed));
    coef_par <= 72'({$random(seed), $random(seed), $random(seed)});
    coef_load <= 1'b1;
    @(posedge core_clk);
    coef_load <= 1'b0;
    fir_en <= 1'b1;
    data_shift <= 1'b1;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    s = '0;
    for (int k = 0; k < 4; k++)
      s = s + sx(72'(hold_val), 18, 1'b1) * sx(coef_par >> 18 * k, 18, 1'b1);
    cmp_w("fir sum", put('0, s, 72, 0), result);
    cmp_w("data tail", 144'(hold_val), 144'(chain_data_out));
    cmp_w("coef tail", 144'(coef_par[71:54]),
      144'(chain_coef_out));
    @(posedge core_clk);
    size <= SZ_9;
    @(posedge core_clk);
    fir_en <= 1'b0;
    repeat (6) @(posedge core_clk);
    report_and_stop();
  end
endmodule
